// [src/bit_manip_pkg.sv]
// Shared types and constants of the bit-manipulation datapath
package bit_manip_pkg;

    localparam int BYTE_W = 8; // Operand width
    localparam int BITNO_W = 3; // Bit number width
    localparam int ADDR_W = 16; // Memory byte address width
    localparam int CARRY_POS = 0; // Carry bit inside the flags register
    localparam int ZERO_POS = 2; // Zero bit inside the flags register
    localparam logic [BYTE_W-1:0] FLAGS_RST = 8'h00; // Flags after reset

    // Operation codes issued by the instruction decoder
    typedef enum logic [3:0] {
        SET_BIT_OP = 4'h0,
        ZERO_BIT_OP = 4'h1,
        FLIP_BIT_OP = 4'h2,
        PROBE_BIT_OP = 4'h3,
        AND_INTO_FLAG_OP = 4'h4,
        AND_INVERTED_INTO_FLAG_OP = 4'h5,
        OR_INTO_FLAG_OP = 4'h6,
        OR_INVERTED_INTO_FLAG_OP = 4'h7,
        XOR_INTO_FLAG_OP = 4'h8,
        XOR_INVERTED_INTO_FLAG_OP = 4'h9,
        LOAD_FLAG_OP = 4'ha,
        LOAD_INVERTED_FLAG_OP = 4'hb,
        STORE_FLAG_OP = 4'hc,
        STORE_INVERTED_FLAG_OP = 4'hd
    } bit_op_t;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_MEM_RD = 4'h2,
        ST_MEM_WR = 4'h4,
        ST_DONE = 4'h8
    } state_t;

    // One request from the decoder
    typedef struct packed {
        bit_op_t op; // Operation
        logic bitno_from_reg; // Bit number from a register, else immediate
        logic [BITNO_W-1:0] imm_bitno; // Immediate bit number
        logic [BYTE_W-1:0] bitno_reg; // Register holding the bit number
        logic use_mem; // Operand lives in memory
        logic [BYTE_W-1:0] reg_operand; // Register operand
        logic [ADDR_W-1:0] mem_addr; // Memory operand address
    } bit_req_t;

    // Result of the bit engine
    typedef struct packed {
        logic [BYTE_W-1:0] data; // Byte to write back
        logic carry; // New carry
        logic zero; // New zero flag
        logic wr_data; // Byte must be written back
        logic wr_carry; // Carry is updated
        logic wr_zero; // Zero flag is updated
    } bit_res_t;

endpackage

// [src/bit_engine.sv]
// Combinational bit engine: one byte, one bit number, one carry in
`timescale 1ns/1ps

module bit_engine (
    input wire bit_manip_pkg::bit_op_t op, // Operation
    input wire logic [bit_manip_pkg::BYTE_W-1:0] operand, // Operand byte
    input wire logic [bit_manip_pkg::BITNO_W-1:0] bitno, // Selected bit
    input wire logic carry_in, // Current carry
    output bit_manip_pkg::bit_res_t res // Result
);

    logic [bit_manip_pkg::BYTE_W-1:0] mask; // One-hot mask of the selected bit
    logic sel; // Value of the selected bit

    // One decoder line per bit position
    for (genvar i = 0; i < bit_manip_pkg::BYTE_W; i++) begin : g_mask
        assign mask[i] = (bitno == bit_manip_pkg::BITNO_W'(i));
    end

    assign sel = |(operand & mask);

    // Only the masked bit ever changes, so the other seven are kept by construction
    always_comb begin
        res = '0;
        res.data = operand;
        case (op)
            bit_manip_pkg::SET_BIT_OP: begin
                res.data = operand | mask;
                res.wr_data = 1'b1;
            end
            bit_manip_pkg::ZERO_BIT_OP: begin
                res.data = operand & ~mask;
                res.wr_data = 1'b1;
            end
            bit_manip_pkg::FLIP_BIT_OP: begin
                res.data = operand ^ mask;
                res.wr_data = 1'b1;
            end
            bit_manip_pkg::PROBE_BIT_OP: begin
                res.zero = ~sel;
                res.wr_zero = 1'b1;
            end
            bit_manip_pkg::AND_INTO_FLAG_OP: res.carry = carry_in & sel;
            bit_manip_pkg::AND_INVERTED_INTO_FLAG_OP: res.carry = carry_in & ~sel;
            bit_manip_pkg::OR_INTO_FLAG_OP: res.carry = carry_in | sel;
            bit_manip_pkg::OR_INVERTED_INTO_FLAG_OP: res.carry = carry_in | ~sel;
            bit_manip_pkg::XOR_INTO_FLAG_OP: res.carry = carry_in ^ sel;
            bit_manip_pkg::XOR_INVERTED_INTO_FLAG_OP: res.carry = carry_in ^ ~sel;
            bit_manip_pkg::LOAD_FLAG_OP: res.carry = sel;
            bit_manip_pkg::LOAD_INVERTED_FLAG_OP: res.carry = ~sel;
            bit_manip_pkg::STORE_FLAG_OP: begin
                res.data = carry_in ? (operand | mask) : (operand & ~mask);
                res.wr_data = 1'b1;
            end
            bit_manip_pkg::STORE_INVERTED_FLAG_OP: begin
                res.data = carry_in ? (operand & ~mask) : (operand | mask);
                res.wr_data = 1'b1;
            end
            default: res.data = operand; // Unknown code leaves everything alone
        endcase
        // Every carry-combining and load form writes the carry
        res.wr_carry = (op >= bit_manip_pkg::AND_INTO_FLAG_OP)
            && (op <= bit_manip_pkg::LOAD_INVERTED_FLAG_OP);
    end

endmodule

// [src/bit_manipulation_unit.sv]
// Bit-manipulation datapath: sequencer, flags register and write-back
`timescale 1ns/1ps

module bit_manipulation_unit (
    input wire logic core_clk, // 40 MHz core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic req_valid, // Decoder offers a request
    input wire bit_manip_pkg::bit_req_t req, // The request
    output logic req_ready, // Unit is idle and takes the request
    input wire logic flags_load, // Decoder writes the whole flags register
    input wire logic [bit_manip_pkg::BYTE_W-1:0] flags_load_data, // Data for it
    output logic [bit_manip_pkg::BYTE_W-1:0] flags, // Flags register
    output logic reg_wr_en, // Write result to the register operand
    output logic [bit_manip_pkg::BYTE_W-1:0] reg_wr_data, // Result byte
    output logic mem_rd_req, // Memory read request
    output logic [bit_manip_pkg::ADDR_W-1:0] mem_addr, // Memory byte address
    input wire logic mem_rd_valid, // Read data is valid
    input wire logic [bit_manip_pkg::BYTE_W-1:0] mem_rd_data, // Read data
    output logic mem_wr_req, // Memory write request
    output logic [bit_manip_pkg::BYTE_W-1:0] mem_wr_data, // Write data
    input wire logic mem_wr_ack, // Write accepted
    output logic done, // Operation finished, one cycle
    output logic illegal // Request refused, one cycle
);

    bit_manip_pkg::state_t state_reg, state_next; // Sequencer
    bit_manip_pkg::bit_req_t req_reg, req_next; // Request held across memory phases
    logic [bit_manip_pkg::BYTE_W-1:0] flags_reg, flags_next; // Condition flags
    logic [bit_manip_pkg::BYTE_W-1:0] data_reg, data_next; // Result byte
    logic reg_wr_en_reg, reg_wr_en_next; // Register write pulse
    logic illegal_reg, illegal_next; // Refusal pulse

    bit_manip_pkg::bit_req_t cur_req; // Request the engine works on
    logic [bit_manip_pkg::BYTE_W-1:0] in_operand; // Engine operand
    logic [bit_manip_pkg::BITNO_W-1:0] sel_bitno; // Engine bit number
    bit_manip_pkg::bit_res_t res; // Engine result
    logic accept; // Request taken this cycle
    logic legal; // Bit number source allowed for the op
    logic apply_now; // Engine result is committed this cycle

    // Only the four single-bit ops may index by register
    function automatic logic reg_bitno_ok(input bit_manip_pkg::bit_op_t op);
        reg_bitno_ok = (op == bit_manip_pkg::SET_BIT_OP)
            || (op == bit_manip_pkg::ZERO_BIT_OP)
            || (op == bit_manip_pkg::FLIP_BIT_OP)
            || (op == bit_manip_pkg::PROBE_BIT_OP);
    endfunction

    assign req_ready = (state_reg == bit_manip_pkg::ST_IDLE);
    assign accept = req_valid && req_ready;
    assign legal = !req.bitno_from_reg || reg_bitno_ok(req.op);

    // Idle works on the live request, later phases on the held copy
    assign cur_req = req_ready ? req : req_reg;
    assign in_operand = cur_req.use_mem ? mem_rd_data : cur_req.reg_operand;
    // Register bit number uses only its low three bits
    assign sel_bitno = cur_req.bitno_from_reg
        ? cur_req.bitno_reg[bit_manip_pkg::BITNO_W-1:0] : cur_req.imm_bitno;

    bit_engine u_engine (
        .op(cur_req.op),
        .operand(in_operand),
        .bitno(sel_bitno),
        .carry_in(flags_reg[bit_manip_pkg::CARRY_POS]),
        .res(res)
    );

    // Result commits either at acceptance of a register op or on read data
    assign apply_now = (accept && legal && !req.use_mem)
        || ((state_reg == bit_manip_pkg::ST_MEM_RD) && mem_rd_valid);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        data_next = data_reg;
        reg_wr_en_next = 1'b0;
        illegal_next = 1'b0;
        case (state_reg)
            bit_manip_pkg::ST_IDLE: begin
                if (accept) begin
                    if (!legal) begin
                        // Refused: nothing changes, unit stays idle
                        illegal_next = 1'b1;
                    end else if (req.use_mem) begin
                        req_next = req;
                        state_next = bit_manip_pkg::ST_MEM_RD;
                    end else begin
                        data_next = res.data;
                        reg_wr_en_next = res.wr_data;
                        state_next = bit_manip_pkg::ST_DONE;
                    end
                end
            end
            bit_manip_pkg::ST_MEM_RD: begin
                if (mem_rd_valid) begin
                    data_next = res.data;
                    // Whole byte goes back; test, load and combine ops skip the write
                    if (res.wr_data) begin
                        state_next = bit_manip_pkg::ST_MEM_WR;
                    end else begin
                        state_next = bit_manip_pkg::ST_DONE;
                    end
                end
            end
            bit_manip_pkg::ST_MEM_WR: begin
                if (mem_wr_ack) begin
                    state_next = bit_manip_pkg::ST_DONE;
                end
            end
            bit_manip_pkg::ST_DONE: begin
                // Not idle here, so register ops come at most every second cycle
                state_next = bit_manip_pkg::ST_IDLE;
            end
            default: begin
                state_next = bit_manip_pkg::ST_IDLE; // Recover from a bad code
            end
        endcase
    end

    // Sequencer registers
    // The held request keeps the memory address steady through read and write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= bit_manip_pkg::ST_IDLE;
            req_reg <= '0;
            data_reg <= '0;
            reg_wr_en_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            data_reg <= data_next;
            reg_wr_en_reg <= reg_wr_en_next;
            illegal_reg <= illegal_next;
        end
    end

    // Flags next value; the unit's own update wins over a decoder load
    // A same-cycle decoder load still lands in the other seven bits
    always_comb begin
        flags_next = flags_load ? flags_load_data : flags_reg;
        if (apply_now && res.wr_carry) begin
            flags_next[bit_manip_pkg::CARRY_POS] = res.carry;
        end
        if (apply_now && res.wr_zero) begin
            flags_next[bit_manip_pkg::ZERO_POS] = res.zero;
        end
    end

    // Flags register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags_reg <= bit_manip_pkg::FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Outputs: handshakes decoded from state, data from flops
    // One-hot decode keeps these strobes to a single gate level
    assign flags = flags_reg;
    assign reg_wr_en = reg_wr_en_reg;
    assign reg_wr_data = data_reg;
    assign mem_wr_data = data_reg;
    assign mem_addr = req_reg.mem_addr;
    assign mem_rd_req = (state_reg == bit_manip_pkg::ST_MEM_RD);
    assign mem_wr_req = (state_reg == bit_manip_pkg::ST_MEM_WR);
    assign done = (state_reg == bit_manip_pkg::ST_DONE);
    assign illegal = illegal_reg;

    // Checks on the unit's own behaviour
    // Helpers below rebuild the mask by a shift, apart from the engine's decoder
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic [bit_manip_pkg::BYTE_W-1:0] sel_mask; // Helper: mask of selected bit
    logic sel_bit; // Helper: selected operand bit
    logic carry_now; // Helper: current carry
    assign sel_mask = bit_manip_pkg::BYTE_W'(1) << sel_bitno;
    assign sel_bit = |(in_operand & sel_mask);
    assign carry_now = flags_reg[bit_manip_pkg::CARRY_POS];

    logic reg_take; // Helper: legal register op taken
    assign reg_take = accept && legal && !req.use_mem;

    set_bit_a: assert property (reg_take && req.op == bit_manip_pkg::SET_BIT_OP
        |=> reg_wr_en && done && reg_wr_data == ($past(in_operand) | $past(sel_mask)))
        else $error("set bit result wrong");

    clear_bit_a: assert property (reg_take && req.op == bit_manip_pkg::ZERO_BIT_OP
        |=> reg_wr_en && reg_wr_data == ($past(in_operand) & ~$past(sel_mask)))
        else $error("clear bit result wrong");

    invert_bit_a: assert property (reg_take && req.op == bit_manip_pkg::FLIP_BIT_OP
        |=> reg_wr_en && reg_wr_data == ($past(in_operand) ^ $past(sel_mask)))
        else $error("invert bit result wrong");

    test_bit_a: assert property (apply_now && cur_req.op == bit_manip_pkg::PROBE_BIT_OP
        |=> flags[bit_manip_pkg::ZERO_POS] == !$past(sel_bit) && !reg_wr_en && !mem_wr_req)
        else $error("test bit zero flag wrong");

    reg_bitno_a: assert property (reg_take && req.bitno_from_reg
        |-> sel_bitno == req.bitno_reg[bit_manip_pkg::BITNO_W-1:0])
        else $error("register bit number not used");

    carry_and_a: assert property (apply_now && cur_req.op == bit_manip_pkg::AND_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) & $past(sel_bit)))
        else $error("and into carry wrong");

    carry_nand_a: assert property (apply_now
        && cur_req.op == bit_manip_pkg::AND_INVERTED_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) & !$past(sel_bit)))
        else $error("inverted and into carry wrong");

    carry_or_a: assert property (apply_now && cur_req.op == bit_manip_pkg::OR_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) | $past(sel_bit)))
        else $error("or into carry wrong");

    carry_nor_a: assert property (apply_now
        && cur_req.op == bit_manip_pkg::OR_INVERTED_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) | !$past(sel_bit)))
        else $error("inverted or into carry wrong");

    carry_xor_a: assert property (apply_now && cur_req.op == bit_manip_pkg::XOR_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) ^ $past(sel_bit)))
        else $error("xor into carry wrong");

    carry_xnor_a: assert property (apply_now
        && cur_req.op == bit_manip_pkg::XOR_INVERTED_INTO_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == ($past(carry_now) ^ !$past(sel_bit)))
        else $error("inverted xor into carry wrong");

    bit_load_a: assert property (apply_now && cur_req.op == bit_manip_pkg::LOAD_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == $past(sel_bit) && !reg_wr_en)
        else $error("bit load wrong");

    bit_nload_a: assert property (apply_now
        && cur_req.op == bit_manip_pkg::LOAD_INVERTED_FLAG_OP
        |=> flags[bit_manip_pkg::CARRY_POS] == !$past(sel_bit))
        else $error("inverted bit load wrong");

    bit_store_a: assert property (reg_take && req.op == bit_manip_pkg::STORE_FLAG_OP
        |=> reg_wr_data == ($past(carry_now) ? ($past(in_operand) | $past(sel_mask))
            : ($past(in_operand) & ~$past(sel_mask))))
        else $error("bit store wrong");

    bit_nstore_a: assert property (reg_take && req.op == bit_manip_pkg::STORE_INVERTED_FLAG_OP
        |=> reg_wr_data == ($past(carry_now) ? ($past(in_operand) & ~$past(sel_mask))
            : ($past(in_operand) | $past(sel_mask))))
        else $error("inverted bit store wrong");

    refuse_reg_a: assert property (accept && req.bitno_from_reg && !reg_bitno_ok(req.op)
        |=> illegal && req_ready && !done && flags == $past(flags_reg) [*1])
        else $error("register bit number not refused");

    // Read phase ends with data, then a write of the changed byte follows
    sequence read_hit_s;
        mem_rd_req && mem_rd_valid && res.wr_data;
    endsequence

    sequence write_back_s;
        mem_wr_req && !mem_rd_req ##0 mem_wr_data == $past(res.data);
    endsequence

    mem_rmw_a: assert property (read_hit_s |=> write_back_s)
        else $error("memory write back missing");

    mem_done_a: assert property (mem_wr_req && mem_wr_ack |=> done ##1 req_ready)
        else $error("memory write did not finish");

    modify_flags_a: assert property (reg_take && res.wr_data && !res.wr_carry && !flags_load
        |=> flags == $past(flags_reg))
        else $error("bit modify touched the flags");

    mem_no_write_a: assert property (mem_rd_req && mem_rd_valid && !res.wr_data
        |=> done && !mem_wr_req)
        else $error("read only memory op wrote back");

    mem_addr_hold_a: assert property (mem_wr_req |-> $stable(mem_addr))
        else $error("memory address moved during write");

    refuse_quiet_a: assert property (illegal |-> !mem_rd_req && !mem_wr_req && !reg_wr_en)
        else $error("refused request still acted");

endmodule

// [test/bit_manipulation_unit_test.sv]
// Self-checking testbench of the bit-manipulation datapath
`timescale 1ns/1ps

module bit_manipulation_unit_test;

    localparam logic [15:0] MEM_ADDR = 16'h4a5c; // Address used for memory operands

    logic core_clk = 1'b0; // Core clock
    logic srst = 1'b1; // Synchronous reset
    logic req_valid = 1'b0; // Request offered
    bit_manip_pkg::bit_req_t req = '0; // Request fields
    logic req_ready; // Unit idle
    logic flags_load = 1'b0; // Whole flags load
    logic [7:0] flags_load_data = 8'h00; // Data for the flags load
    logic [7:0] flags; // Flags register
    logic reg_wr_en; // Register write pulse
    logic [7:0] reg_wr_data; // Register result
    logic mem_rd_req; // Memory read request
    logic [15:0] mem_addr; // Memory address
    logic mem_rd_valid = 1'b0; // Read answer
    logic [7:0] mem_rd_data = 8'h00; // Read data
    logic mem_wr_req; // Memory write request
    logic [7:0] mem_wr_data; // Write data
    logic mem_wr_ack = 1'b0; // Write accepted
    logic done; // Finished pulse
    logic illegal; // Refused pulse
    int mismatches = 0; // Failed comparisons
    int comparisons = 0; // All comparisons
    int cycles = 0; // Hang guard
    logic got_done, got_ill, got_regwr, addr_bad; // Seen in the answer cycle; addr_bad gathered over the read cycles
    logic [7:0] got_data, got_flags, got_memdata; // Captured results
    int got_memwr; // Cycles with a write request up

    bit_manipulation_unit u_bit_manipulation_unit (
        .core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .flags_load(flags_load), .flags_load_data(flags_load_data),
        .flags(flags), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data),
        .mem_wr_ack(mem_wr_ack), .done(done), .illegal(illegal)
    );

    // Free-running clock, half period 12.5 ns
    always #12.5 core_clk = ~core_clk;

    // A hang counts as a mismatch; all tests need well under 5000 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    // Prints the counts and the verdict, then stops
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Byte comparison, four-state exact
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Loads the whole flags register while the unit is idle
    task automatic set_flags(input logic [7:0] v);
        flags_load = 1'b1;
        flags_load_data = v;
        @(posedge core_clk);
        #1;
        flags_load = 1'b0;
    endtask

    // Issues one request, plays a slow memory, captures the answer cycle
    task automatic do_op(input bit_manip_pkg::bit_op_t op, input logic fr, input logic [2:0] imm,
        input logic [7:0] breg, input logic um, input logic [7:0] opnd);
        int n;
        int wait_rd;
        logic rv;
        logic wa;
        got_done = 1'b0;
        got_ill = 1'b0;
        got_regwr = 1'b0;
        addr_bad = 1'b0;
        got_memwr = 0;
        wait_rd = 0;
        req = '{op: op, bitno_from_reg: fr, imm_bitno: imm, bitno_reg: breg, use_mem: um,
            reg_operand: opnd, mem_addr: MEM_ADDR};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        for (n = 0; n < 30; n++) begin
            rv = 1'b0;
            wa = 1'b0;
            if (done === 1'b1 || illegal === 1'b1) begin
                got_done = done;
                got_ill = illegal;
                got_regwr = reg_wr_en;
                got_data = reg_wr_data;
                got_flags = flags;
                break;
            end
            if (mem_rd_req === 1'b1) begin
                addr_bad = addr_bad | (mem_addr !== MEM_ADDR);
                wait_rd++;
                rv = (wait_rd > 2); // Memory stalls two cycles before answering
            end
            if (mem_wr_req === 1'b1) begin
                got_memwr++;
                got_memdata = mem_wr_data;
                wa = (got_memwr > 1); // One stall cycle before the ack
            end
            mem_rd_valid = rv;
            mem_rd_data = rv ? opnd : ~opnd; // Released bus shows the inverse
            mem_wr_ack = wa;
            @(posedge core_clk);
            #1;
        end
        mem_rd_valid = 1'b0; // Memory lets go once the op is over
        mem_wr_ack = 1'b0;
        mem_rd_data = ~opnd;
        chk("answer seen", 8'h01, {7'h00, got_done | got_ill});
        @(posedge core_clk);
        #1;
    endtask

    // Expected carry of the carry-combining and load operations
    function automatic logic new_carry(input bit_manip_pkg::bit_op_t op, input logic c, logic v);
        case (op)
            bit_manip_pkg::AND_INTO_FLAG_OP: return c & v;
            bit_manip_pkg::AND_INVERTED_INTO_FLAG_OP: return c & ~v;
            bit_manip_pkg::OR_INTO_FLAG_OP: return c | v;
            bit_manip_pkg::OR_INVERTED_INTO_FLAG_OP: return c | ~v;
            bit_manip_pkg::XOR_INTO_FLAG_OP: return c ^ v;
            bit_manip_pkg::XOR_INVERTED_INTO_FLAG_OP: return c ^ ~v;
            bit_manip_pkg::LOAD_FLAG_OP: return v;
            bit_manip_pkg::LOAD_INVERTED_FLAG_OP: return ~v;
            default: return c;
        endcase
    endfunction

    // Set, clear, invert on a register, every bit, both bit-number sources
    task automatic t_modify;
        logic [7:0] m;
        logic [7:0] exp;
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 8; b++) begin
                for (int fr = 0; fr < 2; fr++) begin
                    set_flags(8'h5a);
                    m = 8'h01 << b;
                    exp = (i == 0) ? (8'h5a | m) : (i == 1) ? (8'h5a & ~m) : (8'h5a ^ m);
                    // Upper register bits and the unused source both carry wrong values
                    do_op(bit_manip_pkg::bit_op_t'(i), fr[0], fr[0] ? ~b[2:0] : b[2:0],
                        {5'b10110, fr[0] ? b[2:0] : ~b[2:0]}, 1'b0, 8'h5a);
                    chk("modify write enable", 8'h01, {7'h00, got_regwr});
                    chk("modify data", exp, got_data);
                    chk("modify flags", 8'h5a, got_flags);
                end
            end
        end
        $display("test modify finished");
    endtask

    // Test puts the inverted bit into the zero flag, operand untouched
    task automatic t_probe;
        logic [7:0] pre;
        logic [7:0] opnd;
        opnd = 8'h96;
        for (int b = 0; b < 8; b++) begin
            for (int fr = 0; fr < 2; fr++) begin
                pre = fr[0] ? 8'hff : 8'h00;
                set_flags(pre);
                do_op(bit_manip_pkg::PROBE_BIT_OP, fr[0], fr[0] ? 3'h0 : b[2:0],
                    {5'b01001, b[2:0]}, 1'b0, opnd);
                pre[bit_manip_pkg::ZERO_POS] = ~opnd[b];
                chk("probe flags", pre, got_flags);
                chk("probe write enable", 8'h00, {7'h00, got_regwr});
            end
        end
        $display("test probe finished");
    endtask

    // Carry combine, load and store, all carry and bit values
    task automatic t_carry;
        logic [7:0] pre;
        logic [7:0] opnd;
        logic [7:0] exp;
        bit_manip_pkg::bit_op_t op;
        for (int i = 4; i < 14; i++) begin
            for (int cv = 0; cv < 4; cv++) begin
                op = bit_manip_pkg::bit_op_t'(i);
                pre = 8'ha0 | {7'h00, cv[0]};
                opnd = cv[1] ? 8'h08 : 8'hf7;
                set_flags(pre);
                do_op(op, 1'b0, 3'h3, 8'h07, 1'b0, opnd);
                exp = opnd;
                if (i >= 12) begin
                    exp[3] = (i == 12) ? cv[0] : ~cv[0];
                    chk("store write enable", 8'h01, {7'h00, got_regwr});
                    chk("store data", exp, got_data);
                end else begin
                    pre[bit_manip_pkg::CARRY_POS] = new_carry(op, cv[0], cv[1]);
                    chk("carry no write", 8'h00, {7'h00, got_regwr});
                    chk("operand kept", opnd, got_data);
                end
                chk("carry flags", pre, got_flags);
            end
        end
        $display("test carry finished");
    endtask

    // Carry, load and store forms refuse a register bit number
    task automatic t_illegal;
        for (int i = 4; i < 14; i++) begin
            set_flags(8'h21);
            do_op(bit_manip_pkg::bit_op_t'(i), 1'b1, 3'h3, 8'h03, 1'b0, 8'h08);
            chk("refused pulse", 8'h01, {7'h00, got_ill});
            chk("refused no done", 8'h00, {7'h00, got_done});
            chk("refused flags", 8'h21, got_flags);
        end
        $display("test refusal finished");
    endtask

    // Memory operands: read the byte; flip and store write the whole byte back, probe and load do not
    task automatic t_mem;
        bit_manip_pkg::bit_op_t ops[4];
        logic [7:0] exp_fl[4];
        ops = '{bit_manip_pkg::FLIP_BIT_OP, bit_manip_pkg::PROBE_BIT_OP,
            bit_manip_pkg::STORE_FLAG_OP, bit_manip_pkg::LOAD_FLAG_OP};
        exp_fl = '{8'h01, 8'h05, 8'h01, 8'h00};
        for (int i = 0; i < 4; i++) begin
            set_flags(8'h01);
            do_op(ops[i], 1'b0, 3'h5, 8'h00, 1'b1, 8'hc5);
            chk("memory address", 8'h00, {7'h00, addr_bad});
            chk("memory writes", (i % 2 == 0) ? 8'h01 : 8'h00, {7'h00, got_memwr > 0});
            if (i % 2 == 0) begin
                chk("memory byte", 8'he5, got_memdata);
            end
            chk("memory flags", exp_fl[i], got_flags);
            chk("memory no reg write", 8'h00, {7'h00, got_regwr});
        end
        $display("test memory finished");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk("flags after reset", 8'h00, flags);
        chk("ready after reset", 8'h01, {7'h00, req_ready});
        @(posedge core_clk);
        #1;
        t_modify();
        t_probe();
        t_carry();
        t_illegal();
        t_mem();
        wrap_up();
    end

endmodule
